// ===== design/pir_pkg.sv
// Package: offsets, field positions, reset values and FSM codes.
// Assumes one 10 MHz clock and a synchronous active-high reset.
//
// Contract
// [RQ1] Hot mask at 0x05, resets 0x03
// [RQ2] Mask bit 0 enables, 1 suppresses
// [RQ3] Regulator mask low at 0x07, resets 0xff
// [RQ4] Regulator mask high at 0x08, resets 0xff
// [RQ5] Up-down mask at 0x09, resets 0x07
// [RQ6] Hot live state at 0x0a, read only
// [RQ7] Regulator live low at 0x0b, read only
// [RQ8] Regulator live high at 0x0c, read only
// [RQ9] Up-down live state at 0x0d, read only
// [RQ10] Mode register 0x10, four on/low-power pairs
// [RQ11] Output-on bit: 0 off, 1 on
// [RQ12] Low-power bit: 0 normal, 1 low power
// [RQ13] Events latch into read-clear pending flags
// [RQ14] Group mask resets 0x07, 1 masks group
// [RQ15] Interrupt on unmasked pending flag
// [RQ16] Reserved bits read zero, writes ignored
package pir_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_SRC = 8'h00;
  localparam logic [7:0] IDX_PEND_HOT = 8'h01;
  localparam logic [7:0] IDX_PEND_RLO = 8'h02;
  localparam logic [7:0] IDX_PEND_RHI = 8'h03;
  localparam logic [7:0] IDX_PEND_UD = 8'h04;
  localparam logic [7:0] IDX_HOT_MASK = 8'h05;
  localparam logic [7:0] IDX_GRP_MASK = 8'h06;
  localparam logic [7:0] IDX_RLO_MASK = 8'h07;
  localparam logic [7:0] IDX_RHI_MASK = 8'h08;
  localparam logic [7:0] IDX_UD_MASK = 8'h09;
  localparam logic [7:0] IDX_HOT_LIVE = 8'h0a;
  localparam logic [7:0] IDX_RLO_LIVE = 8'h0b;
  localparam logic [7:0] IDX_RHI_LIVE = 8'h0c;
  localparam logic [7:0] IDX_UD_LIVE = 8'h0d;
  localparam logic [7:0] IDX_MODE1 = 8'h10;

  // Address field positions
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned IDX_LSB = 2;

  // Values after reset
  localparam logic [1:0] RST_HOT_MASK = 2'h3;
  localparam logic [7:0] RST_REG_MASK = 8'hff;
  localparam logic [2:0] RST_UD_MASK = 3'h7;
  localparam logic [2:0] RST_GRP_MASK = 3'h7;
  localparam logic [7:0] RST_MODE = 8'h00;

  // Group mask and source bit positions
  localparam int unsigned GRP_HOT = 0;
  localparam int unsigned GRP_REG = 1;
  localparam int unsigned GRP_UD = 2;

  // Bus response states, one bit apart
  typedef enum logic [0:0]
  {
    ST_IDLE = 1'b0,
    ST_RESP = 1'b1
  } pir_bus_st_t;

endpackage

// ===== design/pir_event_latch.sv
// Event latch: registers live state, sets sticky flags on rising edges.
// Assumes the live inputs are synchronous to sys_clk.
`timescale 1ns/10ps
module pir_event_latch #(
  parameter int unsigned W = 8
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [W-1:0] live_in,
  input wire logic clr_en,
  input wire logic [W-1:0] clr_bits,
  output logic [W-1:0] live_q,
  output logic [W-1:0] pend_q
);
  import pir_pkg::*;

  // Whole state of the latch
  typedef struct packed {
    logic [W-1:0] live;
    logic [W-1:0] pend;
  } pir_latch_st_t;

  pir_latch_st_t st_q;
  pir_latch_st_t st_d;
  logic [W-1:0] rise;

  // Next state: new events win over a clear in the same cycle
  always_comb
  begin
    rise = live_in & ~st_q.live;
    st_d = st_q;
    st_d.live = live_in;
    st_d.pend = st_q.pend & ~(clr_en ? clr_bits : '0); // RQ13
    st_d.pend = st_d.pend | rise; // RQ13
  end

  // State register
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign live_q = st_q.live;
  assign pend_q = st_q.pend;

endmodule

// ===== design/pir_apb_slave.sv
// APB slave front end: no wait states, read data from a flop.
// Assumes an APB master that holds its request until pready.
`timescale 1ns/10ps
module pir_apb_slave (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [pir_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic hit_in,
  input wire logic [7:0] rdata_in,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [7:0] idx_q,
  output logic rd_done,
  output logic wr_done
);
  import pir_pkg::*;

  // Whole state of the bus front end
  typedef struct packed {
    pir_bus_st_t st;
    logic [7:0] idx;
    logic hit;
    logic [31:0] rdata;
  } pir_apb_st_t;

  pir_apb_st_t s_q;
  pir_apb_st_t s_d;
  logic done;

  // Setup captures index, hit and read data; access completes
  always_comb
  begin
    s_d = s_q;
    done = (s_q.st == ST_RESP) && psel && penable;
    unique case (s_q.st)
      ST_IDLE:
      begin
        if (psel && !penable)
        begin
          s_d.st = ST_RESP;
          s_d.idx = paddr[IDX_LSB +: 8];
          s_d.hit = hit_in;
          s_d.rdata = {24'h000000, rdata_in}; // RQ16
        end
      end
      ST_RESP:
      begin
        if (done)
        begin
          s_d.st = ST_IDLE;
        end
      end
    endcase
  end

  // State register
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign prdata = s_q.rdata;
  assign pready = (s_q.st == ST_RESP);
  assign pslverr = pready && !s_q.hit;
  assign idx_q = s_q.idx;
  assign rd_done = done && !pwrite && s_q.hit;
  assign wr_done = done && pwrite && s_q.hit;

endmodule

// ===== design/pir_regs.sv
// Interrupt mask, live state, pending and mode registers.
// Assumes synchronous live inputs and an APB master on sys_clk.
//
// Added by the designer: the APB slave port.
`timescale 1ns/10ps
module pir_regs (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [pir_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic hot_first_threshold_flag,
  input wire logic hot_second_threshold_flag,
  input wire logic [7:0] power_good_indication_low,
  input wire logic [6:0] power_good_indication_high,
  input wire logic step_down_power_good_flag,
  input wire logic updown_power_good_flag,
  input wire logic updown_overvoltage_flag,
  input wire logic updown_overcurrent_flag,
  output logic [3:0] linreg_output_on,
  output logic [3:0] linreg_low_power_select,
  output logic irq_out
);
  import pir_pkg::*;

  // Whole state held by this module
  typedef struct packed {
    logic [1:0] hot_mask;
    logic [7:0] rlo_mask;
    logic [7:0] rhi_mask;
    logic [2:0] ud_mask;
    logic [2:0] grp_mask;
    logic [7:0] mode;
  } pir_core_st_t;

  pir_core_st_t c_q;
  pir_core_st_t c_d;

  // Bus front end results
  logic [7:0] idx_q;
  logic rd_done;
  logic wr_done;
  logic hit;
  logic [7:0] rd_val;
  logic [7:0] cur_idx;

  // Live state copies from the latches
  logic [1:0] hot_live;
  logic [7:0] rlo_live;
  logic [7:0] rhi_live;
  logic [2:0] ud_live;

  // Pending flags from the latches
  logic [1:0] hot_pend;
  logic [7:0] rlo_pend;
  logic [7:0] rhi_pend;
  logic [2:0] ud_pend;

  // Per-latch clear enables
  logic clr_hot;
  logic clr_rlo;
  logic clr_rhi;
  logic clr_ud;

  // Write strobe for the low byte lane
  logic wr_lane;

  // Live inputs gathered in register bit order
  logic [1:0] hot_in;
  logic [7:0] rhi_in;
  logic [2:0] ud_in;

  // Group request terms
  logic hot_req;
  logic reg_req;
  logic ud_req;

  // True when the index names a register of this bank
  function automatic logic pir_is_mapped(input logic [7:0] idx);
    logic r;
    r = (idx <= IDX_UD_LIVE) || (idx == IDX_MODE1);
    return r;
  endfunction

  // True when any pending flag is not masked by its own bit
  function automatic logic pir_any_open(
    input logic [7:0] pend,
    input logic [7:0] mask
  );
    logic r;
    r = |(pend & ~mask);
    return r;
  endfunction

  // Inputs in the order the registers show them
  assign hot_in = {hot_first_threshold_flag, hot_second_threshold_flag};
  assign rhi_in = {step_down_power_good_flag, power_good_indication_high};
  assign ud_in = {
    updown_power_good_flag,
    updown_overvoltage_flag,
    updown_overcurrent_flag
  };

  // Thermal events
  pir_event_latch #(
    .W(2)
  ) u_hot (
    .sys_clk(sys_clk),
    .srst(srst),
    .live_in(hot_in),
    .clr_en(clr_hot),
    .clr_bits(prdata[1:0]),
    .live_q(hot_live),
    .pend_q(hot_pend)
  );

  // Linear regulators one to eight
  pir_event_latch #(
    .W(8)
  ) u_rlo (
    .sys_clk(sys_clk),
    .srst(srst),
    .live_in(power_good_indication_low),
    .clr_en(clr_rlo),
    .clr_bits(prdata[7:0]),
    .live_q(rlo_live),
    .pend_q(rlo_pend)
  );

  // Step-down and linear regulators nine to fifteen
  pir_event_latch #(
    .W(8)
  ) u_rhi (
    .sys_clk(sys_clk),
    .srst(srst),
    .live_in(rhi_in),
    .clr_en(clr_rhi),
    .clr_bits(prdata[7:0]),
    .live_q(rhi_live),
    .pend_q(rhi_pend)
  );

  // Up-down converter events
  pir_event_latch #(
    .W(3)
  ) u_ud (
    .sys_clk(sys_clk),
    .srst(srst),
    .live_in(ud_in),
    .clr_en(clr_ud),
    .clr_bits(prdata[2:0]),
    .live_q(ud_live),
    .pend_q(ud_pend)
  );

  // Bus front end
  pir_apb_slave u_apb (
    .sys_clk(sys_clk),
    .srst(srst),
    .paddr(paddr),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .hit_in(hit),
    .rdata_in(rd_val),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .idx_q(idx_q),
    .rd_done(rd_done),
    .wr_done(wr_done)
  );

  // Address decode on the live request
  assign cur_idx = paddr[IDX_LSB +: 8];
  assign hit = pir_is_mapped(cur_idx) && (paddr[ADDR_W-1:IDX_LSB+8] == '0);

  // Read-back mux; reserved bits pad with zero
  always_comb
  begin
    rd_val = 8'h00;
    unique case (cur_idx)
      // Group summary of pending flags
      IDX_SRC:
      begin
        rd_val = {5'h00, |ud_pend, |{rlo_pend, rhi_pend}, |hot_pend};
      end
      // Pending flags, cleared by this read
      IDX_PEND_HOT:
      begin
        rd_val = {6'h00, hot_pend}; // RQ13
      end
      IDX_PEND_RLO:
      begin
        rd_val = rlo_pend; // RQ13
      end
      IDX_PEND_RHI:
      begin
        rd_val = rhi_pend; // RQ13
      end
      IDX_PEND_UD:
      begin
        rd_val = {5'h00, ud_pend}; // RQ13
      end
      // Mask registers
      IDX_HOT_MASK:
      begin
        rd_val = {6'h00, c_q.hot_mask}; // RQ1 RQ16
      end
      IDX_GRP_MASK:
      begin
        rd_val = {5'h00, c_q.grp_mask}; // RQ14 RQ16
      end
      IDX_RLO_MASK:
      begin
        rd_val = c_q.rlo_mask; // RQ3
      end
      IDX_RHI_MASK:
      begin
        rd_val = c_q.rhi_mask; // RQ4
      end
      IDX_UD_MASK:
      begin
        rd_val = {5'h00, c_q.ud_mask}; // RQ5 RQ16
      end
      // Live state registers
      IDX_HOT_LIVE:
      begin
        rd_val = {6'h00, hot_live}; // RQ6 RQ16
      end
      IDX_RLO_LIVE:
      begin
        rd_val = rlo_live; // RQ7
      end
      IDX_RHI_LIVE:
      begin
        rd_val = rhi_live; // RQ8
      end
      IDX_UD_LIVE:
      begin
        rd_val = {5'h00, ud_live}; // RQ9 RQ16
      end
      // Regulator mode
      IDX_MODE1:
      begin
        rd_val = c_q.mode; // RQ10
      end
      // Unmapped reads zero
      default:
      begin
        rd_val = 8'h00;
      end
    endcase
  end

  // Read-clear of pending flags uses the captured read data
  assign clr_hot = rd_done && (idx_q == IDX_PEND_HOT); // RQ13
  assign clr_rlo = rd_done && (idx_q == IDX_PEND_RLO); // RQ13
  assign clr_rhi = rd_done && (idx_q == IDX_PEND_RHI); // RQ13
  assign clr_ud = rd_done && (idx_q == IDX_PEND_UD); // RQ13

  // Only the low byte lane carries register data
  assign wr_lane = wr_done && pstrb[0];

  // Register writes; read-only indices ignore writes
  always_comb
  begin
    c_d = c_q;
    if (wr_lane)
    begin
      unique case (idx_q)
        // Thermal mask, reserved bits dropped
        IDX_HOT_MASK:
        begin
          c_d.hot_mask = pwdata[1:0]; // RQ1 RQ16
        end
        // Group source mask
        IDX_GRP_MASK:
        begin
          c_d.grp_mask = pwdata[2:0]; // RQ14 RQ16
        end
        // Regulator masks
        IDX_RLO_MASK:
        begin
          c_d.rlo_mask = pwdata[7:0]; // RQ3
        end
        IDX_RHI_MASK:
        begin
          c_d.rhi_mask = pwdata[7:0]; // RQ4
        end
        // Up-down mask
        IDX_UD_MASK:
        begin
          c_d.ud_mask = pwdata[2:0]; // RQ5 RQ16
        end
        // Regulator mode pairs
        IDX_MODE1:
        begin
          c_d.mode = pwdata[7:0]; // RQ10
        end
        // Read-only or pending index
        default:
        begin
          c_d = c_q;
        end
      endcase
    end
  end

  // State register with documented reset values
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      c_q.hot_mask <= RST_HOT_MASK; // RQ1
      c_q.rlo_mask <= RST_REG_MASK; // RQ3
      c_q.rhi_mask <= RST_REG_MASK; // RQ4
      c_q.ud_mask <= RST_UD_MASK; // RQ5
      c_q.grp_mask <= RST_GRP_MASK; // RQ14
      c_q.mode <= RST_MODE; // RQ10
    end
    else
    begin
      c_q <= c_d;
    end
  end

  // Mode outputs: odd bit turns output on, even bit picks low power
  always_comb
  begin
    for (int k = 0; k < 4; k++)
    begin
      linreg_output_on[k] = c_q.mode[2*k+1]; // RQ11
      linreg_low_power_select[k] = c_q.mode[2*k]; // RQ12
    end
  end

  // Per-event masks: zero lets the event through
  assign hot_req = pir_any_open({6'h00, hot_pend}, {6'h3f, c_q.hot_mask}); // RQ2
  assign reg_req = pir_any_open(rlo_pend, c_q.rlo_mask)
    || pir_any_open(rhi_pend, c_q.rhi_mask); // RQ2
  assign ud_req = pir_any_open({5'h00, ud_pend}, {5'h1f, c_q.ud_mask}); // RQ2

  // Level interrupt gated by the group mask
  assign irq_out = (hot_req && !c_q.grp_mask[GRP_HOT])
    || (reg_req && !c_q.grp_mask[GRP_REG])
    || (ud_req && !c_q.grp_mask[GRP_UD]); // RQ14 RQ15

endmodule

// ===== dv/pir_regs_monitor.sv
// Checker for the interrupt mask and status bank, on top-level ports.
// Assumes one sys_clk domain and synchronous active-high srst.
`timescale 1ns/10ps
module pir_regs_monitor (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [pir_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [7:0] power_good_indication_low,
  input wire logic [3:0] linreg_output_on,
  input wire logic [3:0] linreg_low_power_select,
  input wire logic irq_out
);
  import pir_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  // Decoded index and completed write access
  wire [7:0] ix = paddr[9:2];
  wire hi0 = paddr[11:10] == 2'b00;
  wire wr_acc = psel && penable && pready && pwrite;
  wire mode_wr = wr_acc && pstrb[0] && hi0 && ix == IDX_MODE1;
  // Written data split into on and low-power bits
  wire [3:0] on_w = {pwdata[7], pwdata[5], pwdata[3], pwdata[1]};
  wire [3:0] lp_w = {pwdata[6], pwdata[4], pwdata[2], pwdata[0]};
  wire setup_rd = psel && !penable && !pwrite;
  chk_mode_on: assert property (mode_wr |=> linreg_output_on == $past(on_w))
    else $error("output on bits differ from written mode");
  chk_mode_lp: assert property (mode_wr |=> linreg_low_power_select == $past(lp_w))
    else $error("low power bits differ from written mode");
  chk_mode_hold: assert property (!mode_wr |=>
    $stable(linreg_output_on) && $stable(linreg_low_power_select))
    else $error("mode outputs moved without a write");
  chk_rst_mode: assert property ($past(srst) |->
    linreg_output_on == 4'h0 && linreg_low_power_select == 4'h0)
    else $error("mode outputs not clear after reset");
  chk_rst_irq: assert property ($past(srst) |-> !irq_out)
    else $error("interrupt high after reset");
  chk_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  chk_hot_rsvd: assert property (pready && !pwrite && ix == IDX_HOT_LIVE
    |-> prdata[7:2] == 6'h0)
    else $error("thermal state reserved bits set");
  chk_ud_rsvd: assert property (pready && !pwrite && (ix == IDX_UD_LIVE
    || ix == IDX_UD_MASK) |-> prdata[7:3] == 5'h0)
    else $error("up-down reserved bits set");
  chk_live_low: assert property (setup_rd && hi0 && ix == IDX_RLO_LIVE
    |=> prdata[7:0] == $past(power_good_indication_low, 2))
    else $error("regulator state read wrong");
  chk_bad_addr: assert property (setup_rd && ix == 8'h0e
    |=> pready && pslverr && prdata == 32'h0)
    else $error("reserved address not refused");
  cover property (mode_wr);
  cover property ($rose(irq_out));
  cover property (pready && pslverr);
endmodule
bind pir_regs pir_regs_monitor u_mon (.sys_clk(sys_clk), .srst(srst), .paddr(paddr),
  .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .power_good_indication_low(power_good_indication_low),
  .linreg_output_on(linreg_output_on),
  .linreg_low_power_select(linreg_low_power_select), .irq_out(irq_out));

// ===== dv/pir_host_model.sv
// Host side APB master model, one transfer per task call.
// Assumes the bench calls xfer from a single process.
`timescale 1ns/10ps
module pir_host_model (
  input wire logic sys_clk,
  output logic [11:0] paddr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // Idle bus at time zero
  initial
  begin
    paddr = 12'h0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = 32'h0;
    pstrb = 4'h0;
  end
  // Setup, access, wait for pready, then release
  task xfer(input logic w, input logic [7:0] ix, input logic [31:0] wd,
    input logic [3:0] st, output logic [31:0] rd, output logic er);
    @(posedge sys_clk);
    paddr <= {2'b00, ix, 2'b00};
    pwrite <= w;
    pwdata <= wd;
    pstrb <= st;
    psel <= 1'b1;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released lines show garbage, not the last value
    paddr <= ~paddr;
    pwdata <= ~pwdata;
  endtask
endmodule

// ===== dv/pir_regs_bench.sv
// Self-checking bench for the interrupt mask and status bank.
// Assumes pir_regs as top and pir_host_model as APB master.
`timescale 1ns/10ps
module pir_regs_bench;
  import pir_pkg::*;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  // Live inputs: hot1 hot2 buck pg_high pg_low ud_pg ud_ov ud_oc
  logic [20:0] ev = 21'h0;
  wire [11:0] paddr;
  wire psel, penable, pwrite, pready, pslverr, irq;
  wire [31:0] pwdata, prdata;
  wire [3:0] pstrb, on, lp;
  int err_count = 0;
  int num_checks = 0;
  int cyc = 0;
  logic [31:0] rd;
  logic er;
  always #50 sys_clk = ~sys_clk;
  pir_host_model host (.sys_clk(sys_clk), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  pir_regs dut (.sys_clk(sys_clk), .srst(srst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .hot_first_threshold_flag(ev[20]),
    .hot_second_threshold_flag(ev[19]), .step_down_power_good_flag(ev[18]),
    .power_good_indication_high(ev[17:11]), .power_good_indication_low(ev[10:3]),
    .updown_power_good_flag(ev[2]), .updown_overvoltage_flag(ev[1]),
    .updown_overcurrent_flag(ev[0]), .linreg_output_on(on),
    .linreg_low_power_select(lp), .irq_out(irq));
  task close_out;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Hang guard
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      err_count++;
      close_out;
    end
  end
  task cmp(string n, logic [31:0] e, logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  task wr(logic [7:0] ix, logic [7:0] d);
    host.xfer(1'b1, ix, {24'h0, d}, 4'hf, rd, er);
  endtask
  task rdc(logic [7:0] ix, logic [7:0] e);
    host.xfer(1'b0, ix, 32'h0, 4'hf, rd, er);
    cmp($sformatf("reg %h", ix), {24'h0, e}, rd);
  endtask
  // Interrupt looked at once flops have settled
  task irqc(logic e);
    @(negedge sys_clk);
    cmp("irq_out", {31'h0, e}, {31'h0, irq});
  endtask
  task t_reset;
    rdc(IDX_HOT_MASK, 8'h03);
    rdc(IDX_RLO_MASK, 8'hff);
    rdc(IDX_RHI_MASK, 8'hff);
    rdc(IDX_UD_MASK, 8'h07);
    rdc(IDX_RLO_LIVE, 8'h00);
    rdc(IDX_RHI_LIVE, 8'h00);
    rdc(IDX_UD_LIVE, 8'h00);
    rdc(IDX_MODE1, 8'h00);
    rdc(IDX_GRP_MASK, 8'h07);
    irqc(1'b0);
    $display("test reset done");
  endtask
  task t_rw;
    wr(IDX_HOT_MASK, 8'hff);
    rdc(IDX_HOT_MASK, 8'h03);
    wr(IDX_UD_MASK, 8'hff);
    rdc(IDX_UD_MASK, 8'h07);
    wr(IDX_RLO_MASK, 8'h00);
    rdc(IDX_RLO_MASK, 8'h00);
    wr(IDX_RHI_MASK, 8'h00);
    rdc(IDX_RHI_MASK, 8'h00);
    wr(IDX_HOT_LIVE, 8'hff);
    rdc(IDX_HOT_LIVE, 8'h00);
    wr(IDX_MODE1, 8'hb4);
    rdc(IDX_MODE1, 8'hb4);
    cmp("output_on", 32'hc, {28'h0, on});
    cmp("low_power", 32'h6, {28'h0, lp});
    // Byte strobe off: write dropped
    host.xfer(1'b1, IDX_MODE1, 32'h4b, 4'h0, rd, er);
    rdc(IDX_MODE1, 8'hb4);
    wr(IDX_HOT_MASK, 8'h00);
    wr(IDX_UD_MASK, 8'h00);
    $display("test rw done");
  endtask
  task t_live;
    @(posedge sys_clk);
    ev <= {2'b10, 1'b1, 7'h5a, 8'ha5, 3'b101};
    repeat (2) @(posedge sys_clk);
    rdc(IDX_HOT_LIVE, 8'h02);
    rdc(IDX_RLO_LIVE, 8'ha5);
    rdc(IDX_RHI_LIVE, 8'hda);
    rdc(IDX_UD_LIVE, 8'h05);
    irqc(1'b0);
    $display("test live done");
  endtask
  task t_irq;
    wr(IDX_GRP_MASK, 8'h00);
    irqc(1'b1);
    rdc(IDX_PEND_HOT, 8'h02);
    rdc(IDX_PEND_RLO, 8'ha5);
    rdc(IDX_PEND_RHI, 8'hda);
    rdc(IDX_PEND_UD, 8'h05);
    irqc(1'b0);
    rdc(IDX_PEND_UD, 8'h00);
    wr(IDX_HOT_MASK, 8'h03);
    @(posedge sys_clk);
    ev[20:19] <= 2'b00;
    @(posedge sys_clk);
    ev[20:19] <= 2'b11;
    repeat (2) @(posedge sys_clk);
    irqc(1'b0);
    wr(IDX_HOT_MASK, 8'h02);
    irqc(1'b1);
    wr(IDX_GRP_MASK, 8'h01);
    irqc(1'b0);
    rdc(IDX_PEND_HOT, 8'h03);
    $display("test irq done");
  endtask
  task t_bad;
    host.xfer(1'b0, 8'h0e, 32'h0, 4'hf, rd, er);
    cmp("pslverr", 32'h1, {31'h0, er});
    cmp("bad rdata", 32'h0, rd);
    $display("test bad done");
  endtask
  // Reset in mid-run: written masks and mode fall back to reset values
  task t_rerun;
    ev <= 21'h0;
    srst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    srst <= 1'b0;
    t_reset;
    cmp("output_on", 32'h0, {28'h0, on});
    cmp("low_power", 32'h0, {28'h0, lp});
    $display("test rerun done");
  endtask
  initial
  begin
    repeat (3) @(posedge sys_clk);
    srst <= 1'b0;
    t_reset;
    t_rw;
    t_live;
    t_irq;
    t_bad;
    t_rerun;
    close_out;
  end
endmodule
